// ---- src/eesc_pkg.sv ----
// Purpose: shared constants and carriers of the enclave extended-state control
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: all offsets are byte addresses of aligned words
package eesc_pkg;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK_LO = 8'h08;
    localparam logic [7:0] OFS_MASK_HI = 8'h0C;
    localparam logic [7:0] OFS_XEN_LO = 8'h10;
    localparam logic [7:0] OFS_XEN_HI = 8'h14;
    localparam logic [7:0] OFS_CTX_LO = 8'h18;
    localparam logic [7:0] OFS_CTX_HI = 8'h1C;
    localparam logic [7:0] OFS_DATA_LO = 8'h20;
    localparam logic [7:0] OFS_DATA_HI = 8'h24;
    localparam logic [7:0] OFS_PAGES = 8'h28;
    localparam logic [7:0] OFS_MISC = 8'h2C;
    localparam logic [7:0] OFS_SATTR_LO = 8'h30;
    localparam logic [7:0] OFS_SATTR_HI = 8'h34;
    localparam logic [7:0] OFS_AMASK_LO = 8'h38;
    localparam logic [7:0] OFS_AMASK_HI = 8'h3C;
    localparam logic [7:0] OFS_SMISC = 8'h40;
    localparam logic [7:0] OFS_MMASK = 8'h44;
    localparam logic [7:0] OFS_XLEN = 8'h48;
    localparam logic [7:0] OFS_MISC_OFS = 8'h4C;
    localparam logic [7:0] OFS_TBL_IDX = 8'h50;
    localparam logic [7:0] OFS_TBL_OFS = 8'h54;
    localparam logic [7:0] OFS_TBL_SIZE = 8'h58;
    localparam logic [7:0] OFS_INFO_LO = 8'h5C;
    localparam logic [7:0] OFS_INFO_HI = 8'h60;
    // status bit positions
    localparam int ST_GP = 0;
    localparam int ST_SIZE_FAIL = 1;
    localparam int ST_INIT_FAIL = 2;
    localparam int ST_INIT_OK = 3;
    localparam int ST_IN_ENCL = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_CREATED = 6;
    localparam int ST_EVT_LSB = 8;
    // frame layout
    localparam logic [31:0] XSAVE_BASE_BYTES = 32'h0000_0240;
    localparam logic [31:0] MASK_COPY_OFS = 32'h0000_0200;
    localparam logic [31:0] XSAVE_REGION_OFS = 32'h0000_0000;
    localparam int PAGE_SHIFT = 12;
    localparam logic [63:0] MASK_LOW_REQ = 64'h0000_0000_0000_0003;
    localparam logic [63:0] XEN_RESET = 64'h0000_0000_0000_0003;
    localparam int FIRST_COMP = 2;
    localparam int LAST_COMP = 63;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_CREATE, CMD_PAGE_LOAD, CMD_SET_CTX, CMD_READ_INFO,
        CMD_INIT, CMD_ENTER, CMD_RESUME, CMD_EXIT, CMD_REPORT, CMD_SET_XEN
    } eesc_cmd_t;

    typedef enum logic [3:0] {
        EV_NONE, EV_EXCEPTION, EV_INTERRUPT, EV_MGMT_INT, EV_NMI, EV_INIT,
        EV_HYP_EXIT, EV_BREAKPOINT, EV_RENDEZVOUS, EV_TEARDOWN
    } eesc_evt_t;

    typedef struct packed {
        logic valid;
        logic blocked;
        eesc_evt_t kind;
    } eesc_event_t;

    typedef struct packed {
        logic valid;
        logic [31:0] offset;
        logic [63:0] data;
    } eesc_frame_wr_t;

    typedef struct packed {
        logic valid;
        logic [63:0] mask;
        logic [31:0] misc;
    } eesc_report_t;
endpackage : eesc_pkg

// ---- src/eesc_core.sv ----
// Purpose: extended-state configuration control of one enclave on one core
// Assumes: ops issued through the command register
// Notes: one wait state on every bus access; command writes stall while busy
// Notes on behaviour
// - create or control-page load sets context word
// - set-context stores any 64-bit value
// - read-info returns context word for any page
// - unblocked events inside enclave start async exit
// - launch teardown message never causes exit
// - only the first event is recorded
// - entry checks mask, saves enable, loads mask
// - exit restores saved extended enable
// - create computes frame size, checks declared size
// - init compares masked attributes and misc select
// - async exit saves, synthesizes; resume restores states
// - mask low two bits must both be set
// - without save support mask upper bits zero
// - mask must be legal extended-enable value
// - declared size counts pages of all regions
// - save region written in non-compacted layout
// - no save support: 576 bytes, copy at 512
// - with support: running end over components
// - save region sits at frame offset 0
// - misc region directly below register region
// - report carries mask and misc select
// - create faults if low mask bits wrong
// - entry/resume fault if mask exceeds enable (code checks this only when xsave_supported is set)
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module eesc_core
    import eesc_pkg::*;
#(
    parameter int GPR_BYTES = 184,
    parameter int MISC_UNIT_BYTES = 16,
    parameter int PAGE_ADDR_W = 64
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic xsave_supported,
    input wire logic xsave_enabled,
    input wire logic os_vector_state_enable,
    input wire logic [63:0] xen_legal_mask,
    input wire logic [PAGE_ADDR_W-1:0] page_translation,
    input eesc_event_t evt_in,
    output eesc_frame_wr_t frame_wr,
    output eesc_report_t report_out,
    output logic state_save_req,
    output logic state_synth_req,
    output logic state_restore_req,
    output logic in_enclave
);
    initial begin
        if (GPR_BYTES < 1 || MISC_UNIT_BYTES < 0 || PAGE_ADDR_W < 1 || PAGE_ADDR_W > 64)
            $error("bad parameters");
    end

    typedef enum logic [2:0] {S_IDLE, S_SIZE, S_SIZE_CHK, S_AEX_SAVE, S_AEX_SYNTH} eesc_state_t;

    function automatic logic [31:0] popcnt32(input logic [31:0] v);
        logic [31:0] n;
        n = 32'h0;
        for (int i = 0; i < 32; i++)
            n = n + {31'h0, v[i]};
        return n;
    endfunction : popcnt32

    function automatic logic [63:0] set_half(input logic [63:0] old, input logic hi,
                                            input logic [31:0] d);
        return hi ? {d, old[31:0]} : {old[63:32], d};
    endfunction : set_half

    eesc_state_t state;
    logic ack;
    logic [63:0] mask, xen, saved_xen, ctx, data, sattr, amask, info;
    logic [31:0] pages, misc_sel, smisc, mmask, xlen, last_sz, misc_ofs;
    logic [5:0] tbl_idx, comp;
    logic [31:0] comp_ofs [64];
    logic [31:0] comp_sz [64];
    logic gp, size_fail, init_fail, init_ok, created, aex_resumable;
    eesc_evt_t evt_code;

    // bus decode
    wire logic access = avs_read | avs_write;
    wire logic cmd_hit = avs_write && (avs_address == OFS_CMD);
    wire logic busy = (state != S_IDLE);
    assign avs_waitrequest = access && (!ack || (cmd_hit && busy));
    wire logic wr_go = ce && avs_write && !avs_waitrequest;
    wire logic rd_go = ce && avs_read && !ack;
    wire logic hi_half = avs_address[2];
    wire eesc_cmd_t cmd = eesc_cmd_t'(avs_writedata[3:0]);
    wire logic run = wr_go && cmd_hit;

    // mask legality
    wire logic low_ok = (mask[1:0] == MASK_LOW_REQ[1:0]);
    wire logic upper_zero = (mask[63:2] == 62'h0);
    wire logic legal_xen = ((mask & ~xen_legal_mask) == 64'h0) && !mask[LAST_COMP];
    wire logic create_bad = !low_ok
        || (!xsave_supported && (!upper_zero || pages == 32'h0))
        || (xsave_supported && !legal_xen);
    wire logic enter_bad = !os_vector_state_enable
        || (xsave_supported && !xsave_enabled && mask != MASK_LOW_REQ)
        || (xsave_supported && ((mask & xen) != mask));

    // frame sizing
    wire logic [31:0] misc_bytes = 32'(popcnt32(misc_sel) * MISC_UNIT_BYTES);
    wire logic [31:0] run_end = xlen + last_sz;
    wire logic take_comp = mask[comp] && (comp_ofs[comp] >= run_end);
    wire logic [31:0] need_bytes = run_end + misc_bytes + 32'(GPR_BYTES);
    wire logic [43:0] have_bytes = {pages, 12'h0};
    wire logic too_small = have_bytes < {12'h0, need_bytes};
    wire logic [31:0] frame_bytes = 32'(have_bytes);

    // init compare
    wire logic attr_match = ((sattr & amask) == (mask & amask));
    wire logic misc_match = ((smisc & mmask) == (misc_sel & mmask));

    // event qualify: teardown and blocked events never exit
    wire logic evt_exits = evt_in.valid && !evt_in.blocked && evt_in.kind != EV_NONE
        && evt_in.kind != EV_TEARDOWN;
    wire logic aex_start = ce && in_enclave && state == S_IDLE && evt_exits && !run;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack <= 1'b0;
        else if (ce)
            ack <= access && !ack ? 1'b1 : (avs_waitrequest ? ack : 1'b0);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0;
        else if (rd_go)
        begin
            case (avs_address)
                OFS_STATUS: avs_readdata <= {20'h0, evt_code, 1'b0, created, busy,
                    in_enclave, init_ok, init_fail, size_fail, gp};
                OFS_MASK_LO: avs_readdata <= mask[31:0];
                OFS_MASK_HI: avs_readdata <= mask[63:32];
                OFS_XEN_LO: avs_readdata <= xen[31:0];
                OFS_XEN_HI: avs_readdata <= xen[63:32];
                OFS_DATA_LO: avs_readdata <= data[31:0];
                OFS_DATA_HI: avs_readdata <= data[63:32];
                OFS_PAGES: avs_readdata <= pages;
                OFS_MISC: avs_readdata <= misc_sel;
                OFS_SATTR_LO: avs_readdata <= sattr[31:0];
                OFS_SATTR_HI: avs_readdata <= sattr[63:32];
                OFS_AMASK_LO: avs_readdata <= amask[31:0];
                OFS_AMASK_HI: avs_readdata <= amask[63:32];
                OFS_SMISC: avs_readdata <= smisc;
                OFS_MMASK: avs_readdata <= mmask;
                OFS_XLEN: avs_readdata <= run_end;
                OFS_MISC_OFS: avs_readdata <= misc_ofs;
                OFS_TBL_IDX: avs_readdata <= {26'h0, tbl_idx};
                OFS_INFO_LO: avs_readdata <= info[31:0];
                OFS_INFO_HI: avs_readdata <= info[63:32];
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // component table, left unreset
    always_ff @(posedge clk)
    begin
        if (wr_go && avs_address == OFS_TBL_OFS)
            comp_ofs[tbl_idx] <= avs_writedata;
        if (wr_go && avs_address == OFS_TBL_SIZE)
            comp_sz[tbl_idx] <= avs_writedata;
    end

    // plain configuration words; frozen inside the enclave
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask <= MASK_LOW_REQ;
            data <= 64'h0;
            pages <= 32'h0;
            misc_sel <= 32'h0;
            sattr <= 64'h0;
            amask <= 64'h0;
            smisc <= 32'h0;
            mmask <= 32'h0;
            tbl_idx <= 6'h0;
        end
        else if (wr_go && !in_enclave)
        begin
            case (avs_address)
                OFS_MASK_LO, OFS_MASK_HI: mask <= set_half(mask, hi_half, avs_writedata);
                OFS_DATA_LO, OFS_DATA_HI: data <= set_half(data, hi_half, avs_writedata);
                OFS_PAGES: pages <= avs_writedata;
                OFS_MISC: misc_sel <= avs_writedata;
                OFS_SATTR_LO, OFS_SATTR_HI: sattr <= set_half(sattr, hi_half, avs_writedata);
                OFS_AMASK_LO, OFS_AMASK_HI: amask <= set_half(amask, hi_half, avs_writedata);
                OFS_SMISC: smisc <= avs_writedata;
                OFS_MMASK: mmask <= avs_writedata;
                OFS_TBL_IDX: tbl_idx <= avs_writedata[5:0];
                default: ;
            endcase
        end
    end

    // operations and async exit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            xen <= XEN_RESET;
            saved_xen <= 64'h0;
            ctx <= 64'h0;
            info <= 64'h0;
            xlen <= XSAVE_BASE_BYTES;
            last_sz <= 32'h0;
            misc_ofs <= 32'h0;
            comp <= 6'h0;
            gp <= 1'b0;
            size_fail <= 1'b0;
            init_fail <= 1'b0;
            init_ok <= 1'b0;
            created <= 1'b0;
            in_enclave <= 1'b0;
            aex_resumable <= 1'b0;
            evt_code <= EV_NONE;
            frame_wr <= '0;
            report_out <= '0;
            state_save_req <= 1'b0;
            state_synth_req <= 1'b0;
            state_restore_req <= 1'b0;
        end
        else if (ce)
        begin
            frame_wr.valid <= 1'b0;
            report_out.valid <= 1'b0;
            state_save_req <= 1'b0;
            state_synth_req <= 1'b0;
            state_restore_req <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (aex_start)
                    begin
                        evt_code <= evt_in.kind;
                        state <= S_AEX_SAVE;
                    end
                    else if (run)
                    begin
                        gp <= 1'b0;
                        case (cmd)
                            CMD_CREATE:
                            begin
                                size_fail <= 1'b0;
                                created <= 1'b0;
                                xlen <= XSAVE_BASE_BYTES;
                                last_sz <= 32'h0;
                                comp <= 6'(FIRST_COMP);
                                if (create_bad || in_enclave)
                                    gp <= 1'b1;
                                else
                                    state <= xsave_supported ? S_SIZE : S_SIZE_CHK;
                            end
                            CMD_PAGE_LOAD:
                            begin
                                ctx <= 64'(page_translation);
                                created <= 1'b1;
                            end
                            CMD_SET_CTX: ctx <= data;
                            CMD_READ_INFO: info <= ctx;
                            CMD_INIT:
                            begin
                                init_ok <= attr_match && misc_match;
                                init_fail <= !(attr_match && misc_match);
                            end
                            CMD_ENTER, CMD_RESUME:
                            begin
                                if (enter_bad || in_enclave || !created)
                                    gp <= 1'b1;
                                else
                                begin
                                    saved_xen <= xen;
                                    xen <= mask;
                                    in_enclave <= 1'b1;
                                    // resume reloads the saved states only when the last exit was an async exit
                                    state_restore_req <= (cmd == CMD_RESUME) && aex_resumable;
                                    evt_code <= EV_NONE;
                                end
                            end
                            CMD_EXIT:
                            begin
                                if (in_enclave)
                                begin
                                    xen <= saved_xen;
                                    in_enclave <= 1'b0;
                                    aex_resumable <= 1'b0;
                                end
                            end
                            CMD_REPORT:
                            begin
                                report_out.valid <= 1'b1;
                                report_out.mask <= mask;
                                report_out.misc <= misc_sel;
                            end
                            CMD_SET_XEN:
                            begin
                                if (in_enclave)
                                    gp <= 1'b1;
                                else
                                    xen <= data;
                            end
                            default: ;
                        endcase
                    end
                end
                S_SIZE:
                begin
                    // one component per cycle keeps the comparator chain short
                    if (take_comp)
                    begin
                        xlen <= comp_ofs[comp];
                        last_sz <= comp_sz[comp];
                    end
                    if (comp == 6'(LAST_COMP))
                        state <= S_SIZE_CHK;
                    else
                        comp <= comp + 6'h1;
                end
                S_SIZE_CHK:
                begin
                    misc_ofs <= frame_bytes - 32'(GPR_BYTES) - misc_bytes;
                    if (too_small)
                    begin
                        size_fail <= 1'b1;
                        gp <= 1'b1;
                    end
                    else
                    begin
                        created <= 1'b1;
                        ctx <= 64'(page_translation);
                    end
                    state <= S_IDLE;
                end
                S_AEX_SAVE:
                begin
                    state_save_req <= 1'b1;
                    if (!xsave_supported)
                    begin
                        frame_wr.valid <= 1'b1;
                        frame_wr.offset <= XSAVE_REGION_OFS + MASK_COPY_OFS;
                        frame_wr.data <= mask;
                    end
                    state <= S_AEX_SYNTH;
                end
                S_AEX_SYNTH:
                begin
                    state_synth_req <= 1'b1;
                    xen <= saved_xen;
                    in_enclave <= 1'b0;
                    aex_resumable <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule : eesc_core

// ---- verif/eesc_core_monitor.sv ----
// Purpose: concurrent checks on the ports of the extended-state control
// Assumes: one clock domain, asynchronous active-low reset
// Notes: event checks hold only while the register bus is idle
`timescale 1ns/1ps
module eesc_core_monitor
    import eesc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic xsave_supported,
    input wire eesc_event_t evt_in,
    input wire eesc_frame_wr_t frame_wr,
    input wire eesc_report_t report_out,
    input wire logic state_save_req,
    input wire logic state_synth_req,
    input wire logic state_restore_req,
    input wire logic in_enclave
);
    wire cmd_acc = avs_write && !avs_waitrequest && ce && avs_address == OFS_CMD;
    wire [3:0] code = avs_writedata[3:0];
    wire cmd_rep = cmd_acc && code == CMD_REPORT;
    wire cmd_res = cmd_acc && code == CMD_RESUME;
    wire cmd_ent = cmd_acc && (code == CMD_ENTER || code == CMD_RESUME);
    wire bus_idle = !avs_read && !avs_write;
    wire ev_exit = in_enclave && evt_in.valid && !evt_in.blocked && bus_idle
        && evt_in.kind inside {[EV_EXCEPTION:EV_RENDEZVOUS]};
    wire ev_down = in_enclave && evt_in.valid && bus_idle && evt_in.kind == EV_TEARDOWN;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence exit_seq;
        state_save_req ##1 (state_synth_req && !in_enclave);
    endsequence

    read_wait_a: assert property ($rose(avs_read) && ce |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait state wrong");
    aex_first_a: assert property (ev_exit && !$past(ev_exit) |-> ##2 exit_seq)
        else $error("event did not exit");
    teardown_stay_a: assert property (ev_down |-> ##2 !state_save_req)
        else $error("teardown caused exit");
    synth_order_a: assert property (state_synth_req |-> $past(state_save_req))
        else $error("synth without save");
    save_inside_a: assert property (state_save_req |-> $past(in_enclave))
        else $error("save outside enclave");
    mask_copy_a: assert property (frame_wr.valid && !xsave_supported |->
        frame_wr.offset == MASK_COPY_OFS && frame_wr.data == MASK_LOW_REQ && state_save_req)
        else $error("mask copy wrong");
    report_cause_a: assert property (report_out.valid |-> $past(cmd_rep) || $past(cmd_rep, 2))
        else $error("report without command");
    entry_cause_a: assert property ($rose(in_enclave) |-> $past(cmd_ent))
        else $error("entry without command");
    restore_cause_a: assert property (state_restore_req |-> $past(cmd_res) || $past(cmd_res, 2))
        else $error("restore without resume");
endmodule : eesc_core_monitor

// ---- verif/test_eesc_core.sv ----
// Purpose: directed test of the enclave extended-state control
// Assumes: commands polled on the busy flag
// Notes: component table is loaded before the save-supported create
`timescale 1ns/1ps
module test_eesc_core;
    import eesc_pkg::*;
    logic clk, rst_n, ce, avs_read, avs_write, avs_waitrequest;
    logic xsave_supported, xsave_enabled, os_vector_state_enable;
    logic state_save_req, state_synth_req, state_restore_req, in_enclave;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_q, fw_ofs, rep_misc;
    logic [63:0] xen_legal_mask, page_translation, fw_dat, rep_mask;
    eesc_event_t evt_in;
    eesc_frame_wr_t frame_wr;
    eesc_report_t report_out;
    int errors, n_checks, cyc, n_save, n_synth, n_rest;

    eesc_core DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .xsave_supported(xsave_supported), .xsave_enabled(xsave_enabled),
        .os_vector_state_enable(os_vector_state_enable), .xen_legal_mask(xen_legal_mask),
        .page_translation(page_translation), .evt_in(evt_in), .frame_wr(frame_wr),
        .report_out(report_out), .state_save_req(state_save_req),
        .state_synth_req(state_synth_req), .state_restore_req(state_restore_req),
        .in_enclave(in_enclave));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (state_save_req === 1'b1) n_save <= n_save + 1;
        if (state_synth_req === 1'b1) n_synth <= n_synth + 1;
        if (state_restore_req === 1'b1) n_rest <= n_rest + 1;
        if (frame_wr.valid === 1'b1) {fw_ofs, fw_dat} <= {frame_wr.offset, frame_wr.data};
        if (report_out.valid === 1'b1) {rep_mask, rep_misc} <= {report_out.mask, report_out.misc};
        if (cyc == 30000)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk32

    task automatic chk_bit(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask : chk_bit

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk32(rd_q, e);
    endtask : rchk

    task automatic w64(input logic [7:0] a, input logic [63:0] d);
        bus(1'b1, a, d[31:0]);
        bus(1'b1, a + 8'h04, d[63:32]);
    endtask : w64

    // leaves the final status word in rd_q
    task automatic cmd(input eesc_cmd_t c);
        bus(1'b1, OFS_CMD, {28'h0, c});
        do bus(1'b0, OFS_STATUS, 32'h0); while (rd_q[ST_BUSY] !== 1'b0);
    endtask : cmd

    task automatic ev(input eesc_evt_t k, input logic b, input eesc_evt_t k2);
        @(posedge clk);
        evt_in <= '{valid: 1'b1, blocked: b, kind: k};
        @(posedge clk);
        evt_in <= '{valid: k2 != EV_NONE, blocked: 1'b0, kind: k2};
        @(posedge clk);
        evt_in <= '0;
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
    endtask : ev

    initial
    begin
        {errors, n_checks, cyc, n_save, n_synth, n_rest} = '0;
        {rst_n, avs_read, avs_write, xsave_supported, xsave_enabled} = '0;
        {avs_address, avs_writedata, evt_in} = '0;
        ce = 1'b1;
        os_vector_state_enable = 1'b1;
        xen_legal_mask = 64'h0000_0000_0000_00FF;
        page_translation = 64'h0000_0001_2345_6000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(OFS_XEN_LO, 32'h0000_0003);
        rchk(OFS_MASK_LO, 32'h0000_0003);
        rchk(8'hFC, 32'h0);
        bus(1'b1, OFS_PAGES, 32'h0000_0001);
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, OFS_MASK_LO, i ? 32'h0000_0007 : 32'h0000_0001);
            cmd(CMD_CREATE);
            chk_bit(rd_q[ST_GP], 1'b1);
        end
        bus(1'b1, OFS_MASK_LO, 32'h0000_0003);
        cmd(CMD_CREATE);
        chk_bit(rd_q[ST_CREATED], 1'b1);
        rchk(OFS_XLEN, 32'h0000_0240);
        rchk(OFS_MISC_OFS, 32'h0000_0F48);
        cmd(CMD_READ_INFO);
        rchk(OFS_INFO_LO, 32'h2345_6000);
        w64(OFS_CTX_LO, 64'h0123_4567_89AB_CDEF);
        w64(OFS_DATA_LO, 64'h0123_4567_89AB_CDEF);
        cmd(CMD_SET_CTX);
        cmd(CMD_READ_INFO);
        rchk(OFS_INFO_LO, 32'h89AB_CDEF);
        rchk(OFS_INFO_HI, 32'h0123_4567);
        page_translation <= 64'h0000_0002_0000_8000;
        cmd(CMD_PAGE_LOAD);
        cmd(CMD_READ_INFO);
        rchk(OFS_INFO_HI, 32'h0000_0002);
        w64(OFS_AMASK_LO, 64'h0000_0000_0000_00FF);
        bus(1'b1, OFS_MMASK, 32'h0000_0001);
        for (int i = 0; i < 3; i++)
        begin
            w64(OFS_SATTR_LO, i == 1 ? 64'h1 : 64'h3);
            bus(1'b1, OFS_SMISC, i == 2 ? 32'h0000_0001 : 32'h0000_0000);
            cmd(CMD_INIT);
            chk_bit(rd_q[ST_INIT_OK], i == 0);
        end
        bus(1'b1, OFS_MISC, 32'h0000_0005);
        cmd(CMD_REPORT);
        chk32(rep_mask[31:0], 32'h0000_0003);
        chk32(rep_misc, 32'h0000_0005);
        cmd(CMD_ENTER);
        ev(EV_INTERRUPT, 1'b1, EV_NONE);
        ev(EV_TEARDOWN, 1'b0, EV_NONE);
        chk_bit(rd_q[ST_IN_ENCL], 1'b1);
        for (int k = 1; k < 9; k++)
        begin
            if (k > 1) cmd(CMD_ENTER);
            ev(eesc_evt_t'(k), 1'b0, k == 1 ? EV_INTERRUPT : EV_NONE);
            chk_bit(rd_q[ST_IN_ENCL], 1'b0);
            chk32({28'h0, rd_q[ST_EVT_LSB+:4]}, k);
        end
        chk32(n_synth, 8);
        chk32(n_save, 8);
        chk32(fw_ofs, MASK_COPY_OFS);
        chk32(fw_dat[31:0], 32'h0000_0003);
        cmd(CMD_RESUME);
        chk32(n_rest, 1);
        cmd(CMD_EXIT);
        {xsave_supported, xsave_enabled} <= 2'b11;
        w64(OFS_DATA_LO, 64'h0000_0000_0000_000F);
        cmd(CMD_SET_XEN);
        for (int i = 2; i < 64; i++)
        begin
            bus(1'b1, OFS_TBL_IDX, i);
            bus(1'b1, OFS_TBL_OFS, i == 2 ? 32'h0000_0240 : 32'h0);
            bus(1'b1, OFS_TBL_SIZE, i == 2 ? 32'h0000_0100 : 32'h0);
        end
        bus(1'b1, OFS_MASK_LO, 32'h0000_0007);
        cmd(CMD_CREATE);
        rchk(OFS_XLEN, 32'h0000_0340);
        rchk(OFS_MISC_OFS, 32'h0000_0F28);
        cmd(CMD_ENTER);
        rchk(OFS_XEN_LO, 32'h0000_0007);
        cmd(CMD_EXIT);
        rchk(OFS_XEN_LO, 32'h0000_000F);
        cmd(CMD_ENTER);
        ev(EV_NMI, 1'b0, EV_NONE);
        rchk(OFS_XEN_LO, 32'h0000_000F);
        w64(OFS_DATA_LO, 64'h0000_0000_0000_0003);
        cmd(CMD_SET_XEN);
        cmd(CMD_RESUME);
        chk_bit(rd_q[ST_GP], 1'b1);
        print_verdict();
    end
endmodule : test_eesc_core

bind eesc_core eesc_core_monitor mon (.clk(clk), .rst_n(rst_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .xsave_supported(xsave_supported), .evt_in(evt_in), .frame_wr(frame_wr),
    .report_out(report_out), .state_save_req(state_save_req),
    .state_synth_req(state_synth_req), .state_restore_req(state_restore_req),
    .in_enclave(in_enclave));
